// ===== rtl/ltpm_pkg.sv
// Constants and carrier types for the logical to physical mapper
package ltpm_pkg;
  // Register indices; byte address is four times the index
  localparam logic [7:0] IDX_CA1_BASE  = 8'h38;
  localparam logic [7:0] IDX_BANK_BASE = 8'h39;
  localparam logic [7:0] IDX_BOUND     = 8'h3A;
  localparam logic [7:0] IDX_LAST_PAGE = 8'h3B;
  localparam logic [7:0] IDX_DECODE    = 8'h3C;
  localparam logic [7:0] IDX_OMC       = 8'h3E;
  // Reset values
  localparam logic [7:0] RST_CA1_BASE  = 8'h00;
  localparam logic [7:0] RST_BANK_BASE = 8'h00;
  localparam logic [7:0] RST_BOUND     = 8'hF0;
  localparam logic [7:0] RST_DECODE    = 8'h00;
  localparam logic [7:0] RST_OMC       = 8'h80;
  // Field positions
  localparam int BND_BANK_LSB   = 0;
  localparam int BND_CA1_LSB    = 4;
  localparam int OMC_FETCH_BIT  = 7;
  localparam int DEC_ROM512_BIT = 0;
  localparam int DEC_ALT_BIT    = 1;
  localparam int DEC_ROMSZ_LSB  = 2;
  localparam int DEC_RAMSZ_LSB  = 5;
  // Physical layout
  localparam int PAGE_BITS      = 12;
  localparam int PHYS_W         = 20;
  localparam int CHIP_W         = 19;
  localparam logic [2:0] SZ_MAX = 3'h4;
  localparam logic [CHIP_W-1:0] SZ_MIN_BYTES = 19'h08000;
  // Wait states added on a fetch cycle
  localparam int FETCH_WAITS    = 1;

  typedef struct packed {
    logic        req;
    logic        fetch;
    logic [15:0] addr;
  } ltpm_cpu_s;

  typedef struct packed {
    logic              strobe;
    logic              rom_sel;
    logic              ram_sel;
    logic [PHYS_W-1:0] phys;
    logic [CHIP_W-1:0] chip;
  } ltpm_mem_s;

  typedef enum logic {WS_IDLE, WS_WAIT} ltpm_ws_e;
endpackage

// ===== rtl/ltpm_mapper.sv
// Logical to physical address mapper with wait-state generator
//
// Decided for this implementation: the APB slave port and the address map.
`timescale 1ns/1ps
// Contract
// - Sixteen-bit logical addresses become twenty-bit physical addresses.
// - Each address is common area 0, bank area or common area 1 by 4K page.
// - Common area 1 uses the common-1 base as translation base.
// - The bank area uses the bank base as translation base.
// - Common area 0 uses base zero, mapping one-to-one at the bottom.
// - Physical address is base shifted left twelve plus logical address.
// - Overlapping or empty areas still translate correctly.
// - Addresses beyond the fitted chip alias modulo its capacity.
// - Decode serves 256K or 512K of ROM and up to 512K of RAM.
// - Standard wait mode adds one wait only on opcode fetches.
// - Alternate wait mode adds no waits at all.
// - Clearing mode bit 7 hides fetch cycles so no waits are added.
// - Common-1 base, bank base and boundary sit at indices 38, 39, 3A.
// - The operation mode control register sits at index 3E.
module ltpm_mapper
  import ltpm_pkg::*;
#(
  parameter int PADDR_W = 12            // APB address width
) (
  input  wire logic               pclk,     // Processor clock
  input  wire logic               presetn,  // Async reset, active low
  input  wire logic               ce,       // Clock enable
  input  wire logic               psel,     // APB select
  input  wire logic               penable,  // APB access phase
  input  wire logic               pwrite,   // APB write
  input  wire logic [PADDR_W-1:0] paddr,    // APB byte address
  input  wire logic [31:0]        pwdata,   // APB write data
  output logic      [31:0]        prdata,   // APB read data
  output logic                    pready,   // APB ready
  output logic                    pslverr,  // APB error, unmapped
  input  wire ltpm_cpu_s          cpu,      // Core memory cycle
  output logic                    cpu_wait, // Stretch current cycle
  output ltpm_mem_s               mem       // Translated cycle
);

  initial begin
    if (PADDR_W < 11) begin
      $error("PADDR_W too small for register indices");
    end
  end

  logic [7:0]  ca1_base_q;
  logic [7:0]  bank_base_q;
  logic [7:0]  bound_q;
  logic [7:0]  decode_q;
  logic [7:0]  omc_q;
  logic [31:0] prdata_q;
  logic        loaded_q;
  ltpm_mem_s   mem_q;
  ltpm_mem_s   mem_d;
  ltpm_ws_e    ws_q;
  ltpm_ws_e    ws_d;

  // APB decode: word aligned, high bits zero
  wire [7:0] idx      = paddr[9:2];
  wire       aligned  = (paddr[1:0] == 2'h0)
                        && (paddr[PADDR_W-1:10] == '0);
  wire       hit_ca1  = aligned && (idx == IDX_CA1_BASE);
  wire       hit_bank = aligned && (idx == IDX_BANK_BASE);
  wire       hit_bnd  = aligned && (idx == IDX_BOUND);
  wire       hit_last = aligned && (idx == IDX_LAST_PAGE);
  wire       hit_dec  = aligned && (idx == IDX_DECODE);
  wire       hit_omc  = aligned && (idx == IDX_OMC);
  wire       mapped   = hit_ca1 || hit_bank || hit_bnd
                        || hit_last || hit_dec || hit_omc;
  wire       wr_ro    = hit_last && pwrite;
  wire       wr_en    = pready && pwrite && mapped && !wr_ro;
  wire [7:0] rd_byte  = hit_ca1  ? ca1_base_q :
                        hit_bank ? bank_base_q :
                        hit_bnd  ? bound_q :
                        hit_last ? mem_q.phys[PHYS_W-1:PAGE_BITS] :
                        hit_dec  ? decode_q :
                        hit_omc  ? omc_q : 8'h00;

  // Ready one enabled cycle after read data was captured
  assign pready  = ce && psel && penable && loaded_q;
  assign pslverr = pready && (!mapped || wr_ro);
  assign prdata  = prdata_q;

  // Read data capture; loaded flag gates the access phase
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_q <= 32'h0000_0000;
      loaded_q <= 1'b0;
    end else if (ce) begin
      prdata_q <= {24'h00_0000, rd_byte};
      loaded_q <= psel && !pready;
    end
  end

  // Register writes take effect only on the ready edge
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ca1_base_q  <= RST_CA1_BASE;
      bank_base_q <= RST_BANK_BASE;
      bound_q     <= RST_BOUND;
      decode_q    <= RST_DECODE;
      omc_q       <= RST_OMC;
    end else if (wr_en) begin
      if (hit_ca1)  ca1_base_q  <= pwdata[7:0];
      if (hit_bank) bank_base_q <= pwdata[7:0];
      if (hit_bnd)  bound_q     <= pwdata[7:0];
      if (hit_dec)  decode_q    <= pwdata[7:0];
      if (hit_omc)  omc_q       <= pwdata[7:0];
    end
  end

  // Area selection on the 4K page number
  wire [3:0] page      = cpu.addr[15:12];
  wire [3:0] bank_lo   = bound_q[BND_BANK_LSB +: 4];
  wire [3:0] ca1_lo    = bound_q[BND_CA1_LSB +: 4];
  // Common 1 wins an overlap so any boundary pair is legal
  wire       in_ca1    = (page >= ca1_lo);
  wire       in_bank   = !in_ca1 && (page >= bank_lo);
  wire [7:0] base      = in_ca1  ? ca1_base_q :
                         in_bank ? bank_base_q :
                                   8'h00;
  // Sum wraps at 1M, as a 20-bit bus does
  wire [PHYS_W-1:0] phys = {base, {PAGE_BITS{1'b0}}}
                           + {4'h0, cpu.addr};

  // Socket decode: ROM low, RAM in the upper half
  wire       rom512    = decode_q[DEC_ROM512_BIT];
  wire [2:0] rom_sz    = decode_q[DEC_ROMSZ_LSB +: 3];
  wire [2:0] ram_sz    = decode_q[DEC_RAMSZ_LSB +: 3];
  wire [2:0] rom_cap   = (rom_sz > SZ_MAX) ? SZ_MAX : rom_sz;
  wire [2:0] ram_cap   = (ram_sz > SZ_MAX) ? SZ_MAX : ram_sz;
  wire       rom_hit   = !phys[19] && (rom512 || !phys[18]);
  wire       ram_hit   = phys[19];
  // Chip capacity is 32K doubled per size step
  wire [CHIP_W-1:0] rom_mask = (SZ_MIN_BYTES << rom_cap) - 19'h00001;
  wire [CHIP_W-1:0] ram_mask = (SZ_MIN_BYTES << ram_cap) - 19'h00001;
  wire [CHIP_W-1:0] chip = phys[CHIP_W-1:0]
                           & (ram_hit ? ram_mask : rom_mask);

  // Wait generator; fetch indication gated by mode bit 7
  wire fetch_seen = cpu.fetch && omc_q[OMC_FETCH_BIT];
  wire alt_mode   = decode_q[DEC_ALT_BIT];
  wire need_wait  = cpu.req && fetch_seen && !alt_mode;
  assign cpu_wait = need_wait && (ws_q == WS_IDLE);
  wire accept     = ce && cpu.req && !cpu_wait;

  // Next state and next output cycle
  always_comb begin
    ws_d = WS_IDLE;
    unique case (ws_q)
      WS_IDLE: ws_d = cpu_wait ? WS_WAIT : WS_IDLE;
      WS_WAIT: ws_d = WS_IDLE;
    endcase
    mem_d         = mem_q;
    mem_d.strobe  = accept;
    if (accept) begin
      mem_d.phys    = phys;
      mem_d.chip    = chip;
      mem_d.rom_sel = rom_hit;
      mem_d.ram_sel = ram_hit;
    end
  end

  // Translated cycle is registered; a wait never loses a request
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ws_q  <= WS_IDLE;
      mem_q <= '0;
    end else if (ce) begin
      ws_q  <= ws_d;
      mem_q <= mem_d;
    end
  end

  assign mem = mem_q;

  // Helper views for the checks below
  wire wr_ca1 = wr_en && hit_ca1;
  wire in_ca0 = !in_ca1 && !in_bank;

  sequence s_fetch_start;
    ce && cpu.req && fetch_seen && !alt_mode && (ws_q == WS_IDLE);
  endsequence

  sequence s_one_wait;
    cpu_wait ##1 (ce && cpu.req) [*1] ##0 !cpu_wait;
  endsequence

  a_ca0_direct: assert property (
    @(posedge pclk) disable iff (!presetn)
    accept && in_ca0 |=> mem.strobe && mem.phys == {4'h0, $past(cpu.addr)})
    else $error("common area 0 not mapped one to one");

  a_bank_base: assert property (
    @(posedge pclk) disable iff (!presetn)
    accept && in_bank |=> mem.phys[11:0] == $past(cpu.addr[11:0])
      && mem.phys[19:12] == $past(bank_base_q + {4'h0, page}))
    else $error("bank area translation wrong");

  a_ca1_base: assert property (
    @(posedge pclk) disable iff (!presetn)
    accept && page >= ca1_lo |=>
      mem.phys[19:12] == $past(ca1_base_q + {4'h0, page}))
    else $error("common area 1 translation wrong");

  a_fetch_wait: assert property (
    @(posedge pclk) disable iff (!presetn)
    s_fetch_start |-> s_one_wait)
    else $error("fetch cycle did not get exactly one wait");

  a_alt_nowait: assert property (
    @(posedge pclk) disable iff (!presetn)
    alt_mode || !cpu.fetch |-> !cpu_wait)
    else $error("wait added outside a standard fetch");

  a_fetch_hidden: assert property (
    @(posedge pclk) disable iff (!presetn)
    !omc_q[OMC_FETCH_BIT] && ce && cpu.req |-> !cpu_wait ##1 mem.strobe)
    else $error("hidden fetch still stretched");

  a_chip_alias: assert property (
    @(posedge pclk) disable iff (!presetn)
    accept && !ram_hit && rom_cap == 3'h0 |=>
      mem.chip[18:15] == 4'h0 && mem.chip[14:0] == mem.phys[14:0])
    else $error("32K chip address not aliased");

  a_rom256_hole: assert property (
    @(posedge pclk) disable iff (!presetn)
    mem.strobe && mem.phys[19:18] == 2'h1 && !rom512 |->
      !mem.rom_sel && !mem.ram_sel)
    else $error("256K ROM decode hit the unfitted range");

  a_reg_write: assert property (
    @(posedge pclk) disable iff (!presetn)
    wr_ca1 |=> ca1_base_q == $past(pwdata[7:0]) && !pready)
    else $error("common 1 base write lost");

  // Ready is a single cycle so a held request is taken once
  a_ready_pulse: assert property (
    @(posedge pclk) disable iff (!presetn)
    pready |=> !pready)
    else $error("ready held longer than one cycle");

  // Unmapped words answer with an error
  a_slverr_unmap: assert property (
    @(posedge pclk) disable iff (!presetn)
    pready && !mapped |-> pslverr)
    else $error("unmapped access without error");

  // Last page view is read only
  a_last_readonly: assert property (
    @(posedge pclk) disable iff (!presetn)
    pready && wr_ro |-> pslverr && !wr_en)
    else $error("read only view accepted a write");

  // Mode register write lands on the ready edge
  a_omc_write: assert property (
    @(posedge pclk) disable iff (!presetn)
    wr_en && hit_omc |=> omc_q == $past(pwdata[7:0]))
    else $error("mode register write lost");

  // Bank base write lands on the ready edge
  a_bank_write: assert property (
    @(posedge pclk) disable iff (!presetn)
    wr_en && hit_bank |=> bank_base_q == $past(pwdata[7:0]))
    else $error("bank base write lost");

  // Boundary write lands on the ready edge
  a_bound_write: assert property (
    @(posedge pclk) disable iff (!presetn)
    wr_en && hit_bnd |=> bound_q == $past(pwdata[7:0]))
    else $error("boundary write lost");

  // Registers are a byte wide; upper read bits stay zero
  a_read_upper: assert property (
    @(posedge pclk) disable iff (!presetn)
    pready |-> prdata[31:8] == 24'h00_0000)
    else $error("upper read data not zero");

  // Offset within a page passes through untouched
  a_page_offset: assert property (
    @(posedge pclk) disable iff (!presetn)
    accept |=> mem.phys[11:0] == $past(cpu.addr[11:0]))
    else $error("page offset altered");

  // Pages below both boundaries are common area 0
  a_ca0_page: assert property (
    @(posedge pclk) disable iff (!presetn)
    accept && page < bank_lo && page < ca1_lo |=>
      mem.phys == {4'h0, $past(cpu.addr)})
    else $error("low page left common area 0");

  // Every accepted cycle gives one strobe
  a_strobe_set: assert property (
    @(posedge pclk) disable iff (!presetn)
    accept |=> mem.strobe)
    else $error("accepted cycle without strobe");

  // No strobe without an accepted cycle
  a_strobe_clear: assert property (
    @(posedge pclk) disable iff (!presetn)
    ce && !accept |=> !mem.strobe)
    else $error("strobe without accepted cycle");

  // Upper half of the physical space is RAM
  a_ram_decode: assert property (
    @(posedge pclk) disable iff (!presetn)
    mem.strobe && mem.phys[19] |-> mem.ram_sel && !mem.rom_sel)
    else $error("upper half not decoded as RAM");

  // Lowest quarter is always ROM
  a_rom_low: assert property (
    @(posedge pclk) disable iff (!presetn)
    mem.strobe && mem.phys[19:18] == 2'h0 |->
      mem.rom_sel && !mem.ram_sel)
    else $error("lowest quarter not decoded as ROM");

  // Smallest RAM chip folds onto 32K
  a_ram_alias: assert property (
    @(posedge pclk) disable iff (!presetn)
    accept && ram_hit && ram_cap == 3'h0 |=> mem.chip[18:15] == 4'h0)
    else $error("32K RAM address not aliased");

  // Clock enable low freezes the cycle state
  a_ce_freeze: assert property (
    @(posedge pclk) disable iff (!presetn)
    !ce |=> $stable(ws_q) && $stable(mem_q))
    else $error("state moved with clock enable low");

  // Wait state lasts a single cycle
  a_wait_single: assert property (
    @(posedge pclk) disable iff (!presetn)
    ws_q == WS_WAIT |-> !cpu_wait)
    else $error("second wait on one fetch");

  // Plain memory cycles are never stretched
  a_plain_nowait: assert property (
    @(posedge pclk) disable iff (!presetn)
    cpu.req && !cpu.fetch |-> !cpu_wait)
    else $error("plain cycle stretched");

endmodule

// ===== tb/ltpm_cpu_model.sv
// Processor core model issuing logical memory cycles
`timescale 1ns/1ps
module ltpm_cpu_model
  import ltpm_pkg::*;
(
  input  wire logic      pclk,     // Processor clock
  input  wire logic      cpu_wait, // Stretch request
  input  wire ltpm_mem_s mem,      // Translated cycle
  output ltpm_cpu_s      cpu       // Issued cycle
);
  initial cpu = '0;
  // One cycle, held until a settled cpu_wait low lets it be taken
  task automatic cycle(input logic f, input logic [15:0] a,
                       output int waits, output ltpm_mem_s got);
    waits = 0;
    cpu <= '{req: 1'b1, fetch: f, addr: a};
    @(posedge pclk);
    while (cpu_wait === 1'b1 && waits < 8) begin
      waits++;
      @(posedge pclk);
    end
    // Released address shows its inverse, never a stale copy
    cpu <= '{req: 1'b0, fetch: 1'b0, addr: ~a};
    @(posedge pclk);
    got = mem;
  endtask
endmodule

// ===== tb/testbench.sv
// Self-checking bench for the address mapper
`timescale 1ns/1ps
`define CHK(g, x) begin checks_done++; if ((g) !== (x)) begin \
  n_mismatch++; $display("wrong value at %0t: %h not %h", $time, g, x); \
  end end
module testbench
  import ltpm_pkg::*;
;
  logic        pclk, presetn, ce, psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic        e, cpu_wait;
  ltpm_cpu_s   cpu;
  ltpm_mem_s   mem;
  int          n_mismatch = 0;
  int          checks_done = 0;

  ltpm_mapper ltpm_mapper_inst (.pclk(pclk), .presetn(presetn), .ce(ce),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .cpu(cpu), .cpu_wait(cpu_wait), .mem(mem));
  ltpm_cpu_model ltpm_cpu_model_inst (.pclk(pclk), .cpu_wait(cpu_wait),
    .mem(mem), .cpu(cpu));

  // Clock, 5 ns period
  always #2.5 pclk = ~pclk;

  task automatic give_verdict;
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  // APB transfer; held until pready is seen high at a rising edge
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [7:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h000000, d};
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rchk(input logic [11:0] a, input logic [31:0] x);
    apb(1'b0, a, 8'h00);
    `CHK(rd, x)
    `CHK(e, 1'b0)
  endtask

  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    apb(1'b1, a, d);
    `CHK(e, 1'b0)
  endtask

  // One core cycle against the translation worked out by hand
  task automatic tchk(input logic f, input logic [15:0] a, input logic ro,
                      input logic ra, input logic [19:0] p,
                      input logic [18:0] c, input int wx);
    int w;
    ltpm_mem_s m;
    ltpm_cpu_model_inst.cycle(f, a, w, m);
    `CHK(m, ltpm_mem_s'{1'b1, ro, ra, p, c})
    `CHK(w, wx)
  endtask

  initial begin
    pclk = 0; presetn = 0; ce = 1; psel = 0; penable = 0; pwrite = 0;
    paddr = '0; pwdata = '0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    rchk(12'h0E0, 32'h00);
    rchk(12'h0E4, 32'h00);
    rchk(12'h0E8, 32'hF0);
    rchk(12'h0F8, 32'h80);
    apb(1'b0, 12'h0FC, 8'h00); `CHK(e, 1'b1)
    apb(1'b1, 12'h0EC, 8'h55); `CHK(e, 1'b1)
    tchk(1, 16'h1234, 1, 0, 20'h01234, 19'h01234, 1);
    tchk(0, 16'h1234, 1, 0, 20'h01234, 19'h01234, 0);
    $display("test reset done");
    wr(12'h0E8, 8'hE2);
    wr(12'h0E4, 8'h05);
    wr(12'h0E0, 8'h10);
    rchk(12'h0E8, 32'hE2);
    tchk(0, 16'h1FFF, 1, 0, 20'h01FFF, 19'h01FFF, 0);
    tchk(0, 16'h2345, 1, 0, 20'h07345, 19'h07345, 0);
    tchk(0, 16'hDFFF, 1, 0, 20'h12FFF, 19'h02FFF, 0);
    tchk(0, 16'hE123, 1, 0, 20'h1E123, 19'h06123, 0);
    $display("test areas done");
    wr(12'h0E0, 8'h80);
    wr(12'h0F0, 8'h80);
    tchk(0, 16'hE123, 0, 1, 20'h8E123, 19'h0E123, 0);
    wr(12'h0E0, 8'h40);
    tchk(0, 16'hE123, 0, 0, 20'h4E123, 19'h06123, 0);
    wr(12'h0F0, 8'h91);
    tchk(0, 16'hE123, 1, 0, 20'h4E123, 19'h4E123, 0);
    rchk(12'h0EC, 32'h4E);
    $display("test decode done");
    wr(12'h0E8, 8'h22);
    wr(12'h0E0, 8'hFF);
    tchk(0, 16'h2000, 1, 0, 20'h01000, 19'h01000, 0);
    tchk(0, 16'hF000, 1, 0, 20'h0E000, 19'h0E000, 0);
    $display("test overlap done");
    tchk(1, 16'hF000, 1, 0, 20'h0E000, 19'h0E000, 1);
    wr(12'h0F0, 8'h93);
    tchk(1, 16'hF000, 1, 0, 20'h0E000, 19'h0E000, 0);
    wr(12'h0F0, 8'h91);
    wr(12'h0F8, 8'h00);
    rchk(12'h0F8, 32'h00);
    tchk(1, 16'hF000, 1, 0, 20'h0E000, 19'h0E000, 0);
    $display("test waits done");
    // Mid-run reset must restore the boundary and mode registers and clear the cycle
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    `CHK(mem, ltpm_mem_s'('0))
    rchk(12'h0E8, 32'hF0);
    rchk(12'h0F8, 32'h80);
    $display("test reset again done");
    give_verdict();
  end

  // Watchdog far beyond the hundred or so cycles the tests need
  initial begin
    #200000;
    n_mismatch++;
    give_verdict();
  end
endmodule
